/* rtl/sca_pkg.sv */
package sca_pkg;
	// ------------------------------------------------------------
	// bus geometry and register offsets
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam logic [ADDR_W-1:0] AUX_OFS = 12'h008;
	localparam logic [ADDR_W-1:0] ID_OFS = 12'hD00;
	localparam logic [ADDR_W-1:0] ICS_OFS = 12'hD04;
	localparam logic [STRB_W-1:0] STRB_ALL = 4'hF;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------
	// auxiliary disable control fields
	// ------------------------------------------------------------
	localparam int AUX_OOO_BIT = 9;
	localparam int AUX_FPCA_BIT = 8;
	localparam int AUX_FOLD_BIT = 2;
	localparam int AUX_WBUF_BIT = 1;
	localparam int AUX_MCYC_BIT = 0;
	localparam logic [DATA_W-1:0] AUX_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// identity fields
	// ------------------------------------------------------------
	localparam int ID_IMPL_LSB = 24;
	localparam int ID_VAR_LSB = 20;
	localparam int ID_CONST_LSB = 16;
	localparam int ID_PART_LSB = 4;
	localparam int ID_REV_LSB = 0;
	localparam logic [3:0] ID_CONST_VAL = 4'hF;

	// ------------------------------------------------------------
	// interrupt control and state fields
	// ------------------------------------------------------------
	localparam int ICS_NMI_SET = 31;
	localparam int ICS_PSV_SET = 28;
	localparam int ICS_PSV_CLR = 27;
	localparam int ICS_TCK_SET = 26;
	localparam int ICS_TCK_CLR = 25;
	localparam int ICS_ISR_PEND = 22;
	localparam int ICS_VPEND_LSB = 12;
	localparam int ICS_RET_BASE = 11;
	localparam int ICS_VACT_LSB = 0;
	localparam int VECT_W = 9;

	// ------------------------------------------------------------
	// pending slots
	// ------------------------------------------------------------
	localparam int PEND_NMI = 0;
	localparam int PEND_PSV = 1;
	localparam int PEND_TCK = 2;
	localparam int PEND_N = 3;

	typedef enum logic [1:0] {SCA_REG_NONE, SCA_REG_AUX, SCA_REG_ID, SCA_REG_ICS} sca_reg_t;

	typedef struct packed {
		logic fp_out_of_order_disable;
		logic fp_context_auto_update_disable;
		logic if_then_overlap_disable;
		logic default_map_write_buffer_off;
		logic multi_cycle_interrupt_block;
	} sca_aux_t;

	typedef struct packed {
		logic [VECT_W-1:0] vect_active;
		logic ret_to_base;
		logic [VECT_W-1:0] vect_pending;
		logic isr_pending;
	} sca_stat_t;

	typedef struct packed {
		logic nmi;
		logic pendable_service_call;
		logic system_tick_timer;
	} sca_entry_t;
endpackage : sca_pkg

/* rtl/sca_sync3.sv */
// ------------------------------------------------------------
// three-stage synchroniser with agreement filter
// ------------------------------------------------------------
module sca_sync3 (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic level_q
);
	logic meta_q;
	logic s2_q;
	logic s3_q;

	// shift chain; meta_q feeds only s2_q
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			s2_q <= meta_q;
			s3_q <= s2_q;
		end
	end

	// accept a new level once stages two and three agree
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end
endmodule : sca_sync3

/* rtl/sca_pend_bit.sv */
// ------------------------------------------------------------
// sticky pending flag, set wins over clear
// ------------------------------------------------------------
module sca_pend_bit (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic set,
	input wire logic clr,
	output logic pend_q
);
	// an event in the clearing cycle is kept
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else if (set) begin
			pend_q <= 1'b1;
		end else if (clr) begin
			pend_q <= 1'b0;
		end
	end
endmodule : sca_pend_bit

/* rtl/sca_sysctl.sv */
// Functional notes
// - aux bit 9 set keeps floating-point completion in order with integer.
// - aux bit 8 set stops automatic update of the fp context active flag.
// - aux bits 9 and 8 exist only when an fpu is present.
// - aux bit 2 written one disables if-then overlap with first block instruction.
// - with folding enabled, first if-then block instruction may overlap the if-then.
// - aux bit 1 one bypasses default-map write buffering, making bus faults precise.
// - write-buffer disable affects only buffers inside the core.
// - aux bit 0 one makes load/store multiple uninterruptible before stacking.
// - identity is read-only: implementer, constant 0xF, part number fields.
// - identity reports 4-bit variant in 23:20 and patch revision in 3:0.
// - status register reports active vector, preemption, pending vector, any pending.
// - separate set and clear pending bits for service call and tick.
// - write one to bit 31 pends nmi, zero no effect, reads pending state.
// - nmi handler entry clears the bit; reassertion during handler sets it.
module sca_sysctl #(
	parameter bit FPU_PRESENT = 1'b1,
	parameter logic [7:0] IMPLEMENTER = 8'h5A, // arbitrary value
	parameter logic [3:0] VARIANT = 4'h1, // arbitrary value
	parameter logic [11:0] PART_NUMBER = 12'h3B7, // arbitrary value
	parameter logic [3:0] REVISION = 4'h2 // arbitrary value
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [sca_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sca_pkg::DATA_W-1:0] pwdata,
	input wire logic [sca_pkg::STRB_W-1:0] pstrb,
	output logic [sca_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nmi_pin,
	input wire sca_pkg::sca_stat_t core_stat,
	input wire sca_pkg::sca_entry_t handler_entry,
	input wire logic fpca_set_req,
	output logic fpca_update_en,
	output sca_pkg::sca_aux_t aux_ctrl,
	output logic [sca_pkg::PEND_N-1:0] pend
);
	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (sca_pkg::ADDR_W < 12) begin : g_chk
		$error("address width too small for register map");
	end
	// read mux and byte-lane logic assume one 32-bit word of four lanes
	if (sca_pkg::DATA_W != 32 || sca_pkg::STRB_W * 8 != sca_pkg::DATA_W) begin : g_chk_data
		$error("data bus must be 32 bits with one strobe per byte");
	end
	// status vectors must not run into their neighbouring fields
	if (sca_pkg::ICS_VPEND_LSB + sca_pkg::VECT_W > sca_pkg::ICS_ISR_PEND ||
		sca_pkg::ICS_VACT_LSB + sca_pkg::VECT_W > sca_pkg::ICS_RET_BASE) begin : g_chk_vect
		$error("status vector width overlaps neighbouring fields");
	end

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// word-aligned offset to register select
	function automatic sca_pkg::sca_reg_t reg_of(input logic [sca_pkg::ADDR_W-1:0] a);
		sca_pkg::sca_reg_t r;
		r = sca_pkg::SCA_REG_NONE;
		if (a == sca_pkg::AUX_OFS) begin
			r = sca_pkg::SCA_REG_AUX;
		end else if (a == sca_pkg::ID_OFS) begin
			r = sca_pkg::SCA_REG_ID;
		end else if (a == sca_pkg::ICS_OFS) begin
			r = sca_pkg::SCA_REG_ICS;
		end
		return r;
	endfunction : reg_of

	// byte strobes widened to a bit mask
	function automatic logic [sca_pkg::DATA_W-1:0] strb_mask(input logic [sca_pkg::STRB_W-1:0] s);
		logic [sca_pkg::DATA_W-1:0] m;
		m = sca_pkg::WORD_ZERO;
		for (int i = 0; i < sca_pkg::STRB_W; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction : strb_mask

	// register word to control set; fp bits only exist with an fpu
	function automatic sca_pkg::sca_aux_t aux_pack(input logic [sca_pkg::DATA_W-1:0] w);
		sca_pkg::sca_aux_t a;
		a.fp_out_of_order_disable = FPU_PRESENT && w[sca_pkg::AUX_OOO_BIT];
		a.fp_context_auto_update_disable = FPU_PRESENT && w[sca_pkg::AUX_FPCA_BIT];
		a.if_then_overlap_disable = w[sca_pkg::AUX_FOLD_BIT];
		a.default_map_write_buffer_off = w[sca_pkg::AUX_WBUF_BIT];
		a.multi_cycle_interrupt_block = w[sca_pkg::AUX_MCYC_BIT];
		return a;
	endfunction : aux_pack

	sca_pkg::sca_reg_t sel_reg;
	logic setup_ph;
	logic access_ph;
	logic wr_acc;
	logic [sca_pkg::DATA_W-1:0] wbits;
	logic aux_wr;
	logic ics_wr;

	// ------------------------------------------------------------
	// apb phase and write qualification
	// ------------------------------------------------------------
	assign sel_reg = reg_of(paddr);
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign wr_acc = access_ph && pwrite;
	assign wbits = pwdata & strb_mask(pstrb);
	assign aux_wr = wr_acc && (sel_reg == sca_pkg::SCA_REG_AUX);
	assign ics_wr = wr_acc && (sel_reg == sca_pkg::SCA_REG_ICS);
	// zero wait states: read data is staged during setup
	assign pready = 1'b1;
	// error on unmapped offsets and on writes to the identity word
	assign pslverr = access_ph && ((sel_reg == sca_pkg::SCA_REG_NONE) ||
		(pwrite && (sel_reg == sca_pkg::SCA_REG_ID)));

	// ------------------------------------------------------------
	// auxiliary disable controls
	// ------------------------------------------------------------
	logic [sca_pkg::STRB_W-1:0] aux_lane;
	sca_pkg::sca_aux_t aux_new;
	assign aux_lane = pstrb;
	assign aux_new = aux_pack(pwdata);

	// byte-lane write; reserved bits are never stored
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_ctrl <= aux_pack(sca_pkg::AUX_RESET);
		end else if (aux_wr) begin
			if (aux_lane[sca_pkg::AUX_OOO_BIT/8]) begin
				aux_ctrl.fp_out_of_order_disable <= aux_new.fp_out_of_order_disable;
				aux_ctrl.fp_context_auto_update_disable <= aux_new.fp_context_auto_update_disable;
			end
			if (aux_lane[sca_pkg::AUX_FOLD_BIT/8]) begin
				aux_ctrl.if_then_overlap_disable <= aux_new.if_then_overlap_disable;
				aux_ctrl.default_map_write_buffer_off <= aux_new.default_map_write_buffer_off;
				aux_ctrl.multi_cycle_interrupt_block <= aux_new.multi_cycle_interrupt_block;
			end
		end
	end

	// fp context flag update is only passed on while not disabled
	assign fpca_update_en = fpca_set_req && !aux_ctrl.fp_context_auto_update_disable;

	// ------------------------------------------------------------
	// nmi pin synchronisation and edge detect
	// ------------------------------------------------------------
	logic nmi_lvl;
	logic nmi_lvl_q;
	logic nmi_rise;

	sca_sync3 u_nmi_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(nmi_pin),
		.level_q(nmi_lvl)
	);

	// previous filtered level for rising-edge detection
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_lvl_q <= 1'b0;
		end else begin
			nmi_lvl_q <= nmi_lvl;
		end
	end

	assign nmi_rise = nmi_lvl && !nmi_lvl_q;

	// ------------------------------------------------------------
	// pending flags for nmi, service call and tick
	// ------------------------------------------------------------
	logic [sca_pkg::PEND_N-1:0] set_v;
	logic [sca_pkg::PEND_N-1:0] clr_v;

	// software set, pin edge; handler entry and software clear
	assign set_v[sca_pkg::PEND_NMI] = (ics_wr && wbits[sca_pkg::ICS_NMI_SET]) || nmi_rise;
	assign clr_v[sca_pkg::PEND_NMI] = handler_entry.nmi;
	assign set_v[sca_pkg::PEND_PSV] = ics_wr && wbits[sca_pkg::ICS_PSV_SET];
	assign clr_v[sca_pkg::PEND_PSV] = (ics_wr && wbits[sca_pkg::ICS_PSV_CLR]) ||
		handler_entry.pendable_service_call;
	assign set_v[sca_pkg::PEND_TCK] = ics_wr && wbits[sca_pkg::ICS_TCK_SET];
	assign clr_v[sca_pkg::PEND_TCK] = (ics_wr && wbits[sca_pkg::ICS_TCK_CLR]) ||
		handler_entry.system_tick_timer;

	for (genvar g = 0; g < sca_pkg::PEND_N; g++) begin : g_pend
		sca_pend_bit u_pend (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.set(set_v[g]),
			.clr(clr_v[g]),
			.pend_q(pend[g])
		);
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [sca_pkg::DATA_W-1:0] aux_rd;
	logic [sca_pkg::DATA_W-1:0] id_rd;
	logic [sca_pkg::DATA_W-1:0] ics_rd;
	logic [sca_pkg::DATA_W-1:0] rd_d;
	logic [sca_pkg::DATA_W-1:0] prdata_q;

	// reserved aux bits read zero
	always_comb begin
		aux_rd = sca_pkg::WORD_ZERO;
		aux_rd[sca_pkg::AUX_OOO_BIT] = aux_ctrl.fp_out_of_order_disable;
		aux_rd[sca_pkg::AUX_FPCA_BIT] = aux_ctrl.fp_context_auto_update_disable;
		aux_rd[sca_pkg::AUX_FOLD_BIT] = aux_ctrl.if_then_overlap_disable;
		aux_rd[sca_pkg::AUX_WBUF_BIT] = aux_ctrl.default_map_write_buffer_off;
		aux_rd[sca_pkg::AUX_MCYC_BIT] = aux_ctrl.multi_cycle_interrupt_block;
	end

	// fixed identity word
	always_comb begin
		id_rd = sca_pkg::WORD_ZERO;
		id_rd[sca_pkg::ID_IMPL_LSB +: 8] = IMPLEMENTER;
		id_rd[sca_pkg::ID_VAR_LSB +: 4] = VARIANT;
		id_rd[sca_pkg::ID_CONST_LSB +: 4] = sca_pkg::ID_CONST_VAL;
		id_rd[sca_pkg::ID_PART_LSB +: 12] = PART_NUMBER;
		id_rd[sca_pkg::ID_REV_LSB +: 4] = REVISION;
	end

	// status and pending view; clear bits read zero
	always_comb begin
		ics_rd = sca_pkg::WORD_ZERO;
		ics_rd[sca_pkg::ICS_NMI_SET] = pend[sca_pkg::PEND_NMI];
		ics_rd[sca_pkg::ICS_PSV_SET] = pend[sca_pkg::PEND_PSV];
		ics_rd[sca_pkg::ICS_TCK_SET] = pend[sca_pkg::PEND_TCK];
		ics_rd[sca_pkg::ICS_ISR_PEND] = core_stat.isr_pending;
		ics_rd[sca_pkg::ICS_VPEND_LSB +: sca_pkg::VECT_W] = core_stat.vect_pending;
		ics_rd[sca_pkg::ICS_RET_BASE] = core_stat.ret_to_base;
		ics_rd[sca_pkg::ICS_VACT_LSB +: sca_pkg::VECT_W] = core_stat.vect_active;
	end

	// select word for the addressed register
	always_comb begin
		rd_d = sca_pkg::WORD_ZERO;
		unique case (sel_reg)
			sca_pkg::SCA_REG_AUX: rd_d = aux_rd;
			sca_pkg::SCA_REG_ID: rd_d = id_rd;
			sca_pkg::SCA_REG_ICS: rd_d = ics_rd;
			sca_pkg::SCA_REG_NONE: rd_d = sca_pkg::WORD_ZERO;
		endcase
	end

	// stage read data in the setup cycle so it is flopped in access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= sca_pkg::WORD_ZERO;
		end else if (setup_ph && !pwrite) begin
			prdata_q <= rd_d;
		end
	end

	assign prdata = prdata_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	aux_fold_wr_a: assert property (aux_wr && pstrb[0] |=>
		aux_ctrl.if_then_overlap_disable == $past(pwdata[sca_pkg::AUX_FOLD_BIT]))
		else $error("if-then overlap disable not written");

	aux_misc_wr_a: assert property (aux_wr && pstrb[0] |=>
		aux_ctrl.default_map_write_buffer_off == $past(pwdata[sca_pkg::AUX_WBUF_BIT]) &&
		aux_ctrl.multi_cycle_interrupt_block == $past(pwdata[sca_pkg::AUX_MCYC_BIT]))
		else $error("write buffer or multi-cycle control not written");

	fp_bits_wr_a: assert property (aux_wr && pstrb[1] |=>
		aux_ctrl.fp_out_of_order_disable == (FPU_PRESENT && $past(pwdata[sca_pkg::AUX_OOO_BIT])))
		else $error("fp out of order disable wrong");

	fpu_absent_a: assert property (!FPU_PRESENT |->
		!aux_ctrl.fp_out_of_order_disable && !aux_ctrl.fp_context_auto_update_disable)
		else $error("fp controls present without fpu");

	fpca_gate_a: assert property (aux_ctrl.fp_context_auto_update_disable |-> !fpca_update_en)
		else $error("fp context update passed while disabled");

	id_read_a: assert property (setup_ph && !pwrite && sel_reg == sca_pkg::SCA_REG_ID |=>
		prdata[31:24] == IMPLEMENTER && prdata[19:16] == sca_pkg::ID_CONST_VAL &&
		prdata[15:4] == PART_NUMBER && prdata[23:20] == VARIANT && prdata[3:0] == REVISION)
		else $error("identity read value wrong");

	aux_rsv_a: assert property (setup_ph && !pwrite && sel_reg == sca_pkg::SCA_REG_AUX |=>
		prdata[31:10] == 22'h00_0000 && prdata[7:3] == 5'h00)
		else $error("aux reserved bits not zero");

	nmi_set_a: assert property (ics_wr && wbits[sca_pkg::ICS_NMI_SET] |=> pend[sca_pkg::PEND_NMI])
		else $error("nmi not pending after software set");

	nmi_zero_a: assert property (ics_wr && !wbits[sca_pkg::ICS_NMI_SET] && !nmi_rise &&
		!handler_entry.nmi |=> $stable(pend[sca_pkg::PEND_NMI]))
		else $error("writing zero changed nmi pending");

	nmi_entry_a: assert property (handler_entry.nmi && !set_v[sca_pkg::PEND_NMI] |=>
		!pend[sca_pkg::PEND_NMI])
		else $error("handler entry did not clear nmi pending");

	nmi_pin_a: assert property ($rose(nmi_lvl) |=> pend[sca_pkg::PEND_NMI])
		else $error("nmi reassertion not recorded");

	psv_clr_a: assert property (ics_wr && wbits[sca_pkg::ICS_PSV_CLR] && !wbits[sca_pkg::ICS_PSV_SET] |=>
		!pend[sca_pkg::PEND_PSV])
		else $error("service call clear failed");

	tck_clr_a: assert property (ics_wr && wbits[sca_pkg::ICS_TCK_CLR] && !wbits[sca_pkg::ICS_TCK_SET] |=>
		!pend[sca_pkg::PEND_TCK])
		else $error("tick clear failed");

	psv_set_a: assert property (ics_wr && wbits[sca_pkg::ICS_PSV_SET] |=> pend[sca_pkg::PEND_PSV])
		else $error("service call not pending after set");

	tck_set_a: assert property (ics_wr && wbits[sca_pkg::ICS_TCK_SET] |=> pend[sca_pkg::PEND_TCK])
		else $error("tick not pending after set");

	fpca_bit_wr_a: assert property (aux_wr && pstrb[1] |=>
		aux_ctrl.fp_context_auto_update_disable == (FPU_PRESENT && $past(pwdata[sca_pkg::AUX_FPCA_BIT])))
		else $error("fp context update disable wrong");

	aux_lane_a: assert property (aux_wr && !pstrb[0] |=>
		$stable(aux_ctrl.if_then_overlap_disable) && $stable(aux_ctrl.default_map_write_buffer_off) &&
		$stable(aux_ctrl.multi_cycle_interrupt_block))
		else $error("aux low lane changed without its strobe");

	ics_read_a: assert property (setup_ph && !pwrite && sel_reg == sca_pkg::SCA_REG_ICS |=>
		prdata[sca_pkg::ICS_ISR_PEND] == $past(core_stat.isr_pending) &&
		prdata[sca_pkg::ICS_VACT_LSB +: sca_pkg::VECT_W] == $past(core_stat.vect_active) &&
		prdata[sca_pkg::ICS_NMI_SET] == $past(pend[sca_pkg::PEND_NMI]))
		else $error("status read value wrong");

	id_wr_err_a: assert property (access_ph && pwrite && sel_reg == sca_pkg::SCA_REG_ID |-> pslverr)
		else $error("identity write not refused");

	aux_cov_c: cover property (aux_wr ##1 aux_ctrl.multi_cycle_interrupt_block);
	nmi_cov_c: cover property (pend[sca_pkg::PEND_NMI] ##1 handler_entry.nmi ##[1:32] nmi_rise);
	ics_cov_c: cover property (ics_wr && wbits[sca_pkg::ICS_PSV_SET] && wbits[sca_pkg::ICS_PSV_CLR]);
	id_cov_c: cover property (access_ph && !pwrite && sel_reg == sca_pkg::SCA_REG_ID);
	err_cov_c: cover property (pslverr);
endmodule : sca_sysctl

/* sim/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// constants, stimulus and observed signals
	// ------------------------------------------------------------
	localparam logic [7:0] T_IMPL = 8'h3C; // arbitrary value
	localparam logic [3:0] T_VAR = 4'h3; // arbitrary value
	localparam logic [11:0] T_PART = 12'h5E1; // arbitrary value
	localparam logic [3:0] T_REV = 4'h6; // arbitrary value
	localparam logic [31:0] ID_EXP = {T_IMPL, T_VAR, 4'hF, T_PART, T_REV};
	localparam logic [31:0] AUX_MASK = 32'h0000_0307;
	localparam int MAX_CYCLES = 20000;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [sca_pkg::ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [sca_pkg::DATA_W-1:0] pwdata = '0;
	logic [sca_pkg::STRB_W-1:0] pstrb = '0;
	logic [sca_pkg::DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic nmi_pin = 1'b0;
	sca_pkg::sca_stat_t core_stat = '0;
	sca_pkg::sca_entry_t handler_entry = '0;
	logic fpca_set_req = 1'b0;
	logic fpca_update_en;
	sca_pkg::sca_aux_t aux_ctrl;
	logic [sca_pkg::PEND_N-1:0] pend;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] aux_m = '0;
	logic [2:0] pend_m = '0;
	logic [31:0] rd;
	logic err;
	sca_pkg::sca_aux_t aux_nofpu;
	logic [31:0] rd_nofpu;

	sca_sysctl #(
		.FPU_PRESENT(1'b1), .IMPLEMENTER(T_IMPL), .VARIANT(T_VAR), .PART_NUMBER(T_PART), .REVISION(T_REV)
	) sca_sysctl_inst (
		.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nmi_pin(nmi_pin), .core_stat(core_stat), .handler_entry(handler_entry),
		.fpca_set_req(fpca_set_req), .fpca_update_en(fpca_update_en), .aux_ctrl(aux_ctrl), .pend(pend)
	);

	// second copy without an fpu on the same bus, to see the fp bits vanish
	sca_sysctl #(
		.FPU_PRESENT(1'b0)
	) sca_sysctl_nofpu_inst (
		.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(rd_nofpu), .pready(),
		.pslverr(), .nmi_pin(nmi_pin), .core_stat(core_stat), .handler_entry(handler_entry),
		.fpca_set_req(fpca_set_req), .fpca_update_en(), .aux_ctrl(aux_nofpu), .pend()
	);

	// clock generation and hang guard
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == MAX_CYCLES) begin
			miscompares = miscompares + 1;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// one apb transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [3:0] st);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= addr;
		pwrite <= wr;
		pwdata <= wd;
		pstrb <= st;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, addr, 32'h0000_0000, 4'h0);
		chk(rd, exp, "read data");
		chk({31'b0, err}, {31'b0, exp_err}, "slave error");
	endtask : rd_chk

	// write the auxiliary register and track its expected contents lane by lane
	task automatic aux_wr(input logic [31:0] wd, input logic [3:0] st);
		apb(1'b1, sca_pkg::AUX_OFS, wd, st);
		for (int b = 0; b < 4; b++) begin
			if (st[b]) aux_m[8*b +: 8] = wd[8*b +: 8];
		end
		aux_m = aux_m & AUX_MASK;
	endtask : aux_wr

	task automatic pend_chk();
		@(negedge core_clk);
		chk({29'b0, pend}, {29'b0, pend_m}, "pending flags");
	endtask : pend_chk

	task automatic entry_pulse(input logic [2:0] e);
		@(posedge core_clk);
		handler_entry <= e;
		@(posedge core_clk);
		handler_entry <= '0;
	endtask : entry_pulse

	// bounded wait for the synchronised pin to raise the nmi flag
	task automatic wait_nmi();
		int n;
		n = 0;
		while (pend[0] !== 1'b1 && n < 12) begin
			@(posedge core_clk);
			n++;
		end
	endtask : wait_nmi

	function automatic logic [31:0] ics_exp(input logic [2:0] pm, input sca_pkg::sca_stat_t s);
		logic [31:0] v;
		v = '0;
		v[31] = pm[0];
		v[28] = pm[1];
		v[26] = pm[2];
		v[22] = s.isr_pending;
		v[20:12] = s.vect_pending;
		v[11] = s.ret_to_base;
		v[8:0] = s.vect_active;
		return v;
	endfunction : ics_exp

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] w;
		logic [3:0] st;
		int sb;
		void'($urandom(32'h280E));
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk({27'b0, aux_ctrl}, 32'h0, "aux outputs after reset");
		pend_chk();
		// random auxiliary writes, reserved bits and partial strobes among them
		for (int i = 0; i < 40; i++) begin
			w = (i == 0) ? 32'hFFFF_FFFF : ((i == 1) ? 32'h0000_0000 : $urandom());
			st = (i < 4) ? 4'hF : 4'($urandom());
			aux_wr(w, st);
			fpca_set_req <= i[0];
			core_stat <= 20'($urandom());
			@(negedge core_clk);
			chk({27'b0, aux_ctrl}, {27'b0, aux_m[9], aux_m[8], aux_m[2], aux_m[1], aux_m[0]}, "aux outputs");
			chk({31'b0, fpca_update_en}, {31'b0, i[0] & ~aux_m[8]}, "fp flag update enable");
			chk({27'b0, aux_nofpu}, {29'h0000_0000, aux_m[2:0]}, "aux outputs without fpu");
			rd_chk(sca_pkg::AUX_OFS, aux_m, 1'b0);
			chk(rd_nofpu, aux_m & 32'h0000_0007, "aux read without fpu");
			rd_chk(sca_pkg::ICS_OFS, ics_exp(pend_m, core_stat), 1'b0);
		end
		// identity is read-only; unmapped offsets are refused
		rd_chk(sca_pkg::ID_OFS, ID_EXP, 1'b0);
		apb(1'b1, sca_pkg::ID_OFS, 32'h0000_0000, 4'hF);
		chk({31'b0, err}, 32'h0000_0001, "identity write refused");
		rd_chk(sca_pkg::ID_OFS, ID_EXP, 1'b0);
		rd_chk(12'h100, 32'h0000_0000, 1'b1);
		apb(1'b1, 12'h100, 32'hFFFF_FFFF, 4'hF);
		rd_chk(sca_pkg::AUX_OFS, aux_m, 1'b0);
		// software nmi pending: zero writes do nothing, handler entry clears
		apb(1'b1, sca_pkg::ICS_OFS, 32'h0000_0000, 4'hF);
		pend_chk();
		apb(1'b1, sca_pkg::ICS_OFS, 32'h8000_0000, 4'hF);
		pend_m[0] = 1'b1;
		pend_chk();
		apb(1'b1, sca_pkg::ICS_OFS, 32'h0000_0000, 4'hF);
		pend_chk();
		rd_chk(sca_pkg::ICS_OFS, ics_exp(pend_m, core_stat), 1'b0);
		entry_pulse(3'b100);
		pend_m[0] = 1'b0;
		pend_chk();
		rd_chk(sca_pkg::ICS_OFS, ics_exp(pend_m, core_stat), 1'b0);
		// pin-driven nmi, held across entry, then reasserted inside the handler
		@(posedge core_clk);
		nmi_pin <= 1'b1;
		wait_nmi();
		pend_m[0] = 1'b1;
		pend_chk();
		entry_pulse(3'b100);
		pend_m[0] = 1'b0;
		pend_chk();
		@(posedge core_clk);
		nmi_pin <= 1'b0;
		repeat (8) @(posedge core_clk);
		pend_chk();
		@(posedge core_clk);
		nmi_pin <= 1'b1;
		wait_nmi();
		pend_m[0] = 1'b1;
		pend_chk();
		entry_pulse(3'b100);
		pend_m[0] = 1'b0;
		pend_chk();
		// service call and tick: set, clear, set with clear, entry clear
		for (int k = 1; k <= 2; k++) begin
			sb = (k == 1) ? sca_pkg::ICS_PSV_SET : sca_pkg::ICS_TCK_SET;
			apb(1'b1, sca_pkg::ICS_OFS, 32'h0000_0001 << sb, 4'hF);
			pend_m[k] = 1'b1;
			pend_chk();
			apb(1'b1, sca_pkg::ICS_OFS, 32'h0000_0001 << (sb - 1), 4'hF);
			pend_m[k] = 1'b0;
			pend_chk();
			apb(1'b1, sca_pkg::ICS_OFS, 32'h0000_0003 << (sb - 1), 4'hF);
			pend_m[k] = 1'b1;
			pend_chk();
			rd_chk(sca_pkg::ICS_OFS, ics_exp(pend_m, core_stat), 1'b0);
			entry_pulse((k == 1) ? 3'b010 : 3'b001);
			pend_m[k] = 1'b0;
			pend_chk();
		end
		give_verdict();
	end
endmodule : tb
